// [abg_defs.vh]
// abg_defs.vh - constants of the artifact blanking gate
// assumes: included by bare name from the gate and the bench
`ifndef ABG_DEFS_VH
`define ABG_DEFS_VH

// register word offsets on the plain register port
`define ABG_REG_CTRL    4'h0
`define ABG_REG_ONSET   4'h1
`define ABG_REG_OFFSET  4'h2
`define ABG_REG_RAMP    4'h3
`define ABG_REG_STATUS  4'h4

// control register bit positions
`define ABG_CTRL_INVERT 0
`define ABG_CTRL_EXPORT 1
`define ABG_CTRL_STORE  2
`define ABG_CTRL_OFSREL 3

// reset values
`define ABG_RST_CTRL    16'h0000
`define ABG_RST_ONSET   16'h0000
`define ABG_RST_OFFSET  16'h0000
`define ABG_RST_RAMP    16'h0000

// gate states
`define ABG_ST_IDLE     3'h0
`define ABG_ST_WAIT     3'h1
`define ABG_ST_FALL     3'h2
`define ABG_ST_HOLD     3'h3
`define ABG_ST_RISE     3'h4

// ramp shaping: table steps, shortest tapered ramp in samples
`define ABG_STEPS       5'h10
`define ABG_ACC_STEP    20'h00010
`define ABG_SQ_MIN      16'h0004
// full cos2 span is about 1.6875 times the 10..90 percent time
`define ABG_SPAN_MUL    20'h0000B

`endif

// [abg_fifo.v]
// abg_fifo.v - small synchronous fifo with valid/ready on both sides
// assumes: one clock, asynchronous active-low reset, depth a power of two
`timescale 1ns/1ps
`default_nettype none

module abg_fifo #(
    parameter W  = 17,
    parameter D  = 4,
    parameter AW = 2
) (
    input  wire          mclk_i,
    input  wire          rstn_i,
    input  wire          in_valid_i,
    input  wire [W-1:0]  in_data_i,
    output reg           in_ready_o,
    output wire          out_valid_o,
    output wire [W-1:0]  out_data_o,
    input  wire          out_ready_i
);
    reg  [W-1:0] mem [0:D-1];
    reg  [AW-1:0] wp_r;
    reg  [AW-1:0] rp_r;
    reg  [AW:0]   cnt_r;
    wire          push;
    wire          pop;
    wire [AW:0]   cnt_nxt;

    // ready is registered so it has no combinational path from the drain side
    assign push        = in_valid_i & in_ready_o;
    assign pop         = out_valid_o & out_ready_i;
    assign out_valid_o = (cnt_r != {(AW+1){1'b0}});
    assign out_data_o  = mem[rp_r];
    assign cnt_nxt     = cnt_r + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};

    // storage, no reset needed
    always @(posedge mclk_i) begin
        if (push) begin
            mem[wp_r] <= in_data_i;
        end
    end

    // pointers, level and honest full
    always @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            wp_r       <= {AW{1'b0}};
            rp_r       <= {AW{1'b0}};
            cnt_r      <= {(AW+1){1'b0}};
            in_ready_o <= 1'b0;
        end else begin
            if (push) begin
                wp_r <= wp_r + {{(AW-1){1'b0}}, 1'b1};
            end
            if (pop) begin
                rp_r <= rp_r + {{(AW-1){1'b0}}, 1'b1};
            end
            cnt_r      <= cnt_nxt;
            in_ready_o <= (cnt_nxt < D[AW:0]);
        end
    end
endmodule

`default_nettype wire

// [abg_gate.v]
// abg_gate.v - multichannel blanking gate for stimulus artifacts
// assumes: stream and trigger come from logic on mclk_i; registers via plain port
//
// Summary of operation
// R1 - zero every channel inside a window placed relative to each trigger seen while idle
// R2 - gate edges follow a cosine-squared gain shape on all channels
// R3 - ramp time is the 90 percent fall and 90 percent rise time
// R4 - ramp under four samples gives square edges, gain zero at once
// R5 - negative onset delays the data by that many samples
// R6 - invert option flips trigger polarity before edge detection
// R7 - onset and offset count samples from the trigger onset
// R8 - onset and offset may change while running, used at next trigger
// R9 - export option drives the gate waveform as an output
// R10 - store option forwards the gate waveform to the storage path
// R11 - offset-from-gate-start option counts offset from the gate onset
// R12 - outside the gate data pass at unity gain, no extra latency
//
// Implementation choices: the register addresses and strobed register access.
`timescale 1ns/1ps
`default_nettype none
`include "abg_defs.vh"

module abg_gate #(
    parameter NCH   = 4,
    parameter DW    = 16,
    parameter FDEP  = 4,
    parameter FAW   = 2,
    parameter DDEP  = 1024,
    parameter DAW   = 10
) (
    input  wire              mclk_i,
    input  wire              rstn_i,
    input  wire [3:0]        reg_addr_i,
    input  wire [15:0]       reg_wdata_i,
    input  wire              reg_wr_i,
    input  wire              reg_rd_i,
    output reg  [15:0]       reg_rdata_o,
    input  wire              s_valid_i,
    input  wire [NCH*DW-1:0] s_data_i,
    input  wire              s_trig_i,
    output wire              s_ready_o,
    output reg               m_valid_o,
    output reg  [NCH*DW-1:0] m_data_o,
    input  wire              m_ready_i,
    output reg               gate_o,
    output reg               tank_valid_o,
    output reg               tank_gate_o
);
    localparam W = NCH*DW;

    // software registers
    reg  [15:0]     ctrl_r;
    reg  [15:0]     onset_r;
    reg  [15:0]     offset_r;
    reg  [15:0]     ramp_r;

    // gate state
    reg  [2:0]      st_r;
    reg  [4:0]      idx_r;
    reg  [19:0]     acc_r;
    reg  [16:0]     cnt_r;
    reg  [16:0]     on_l_r;
    reg  [16:0]     off_l_r;
    reg             trig_last_r;
    reg  [DAW-1:0]  wp_r;
    reg  [W-1:0]    dmem [0:DDEP-1];

    // next values
    reg  [2:0]      st_nxt;
    reg  [4:0]      idx_nxt;
    reg  [19:0]     acc_nxt;
    reg  [16:0]     cnt_nxt;
    reg  [16:0]     on_nxt;
    reg  [16:0]     off_nxt;

    wire            f_valid;
    wire [W:0]      f_data;
    wire            f_ready;
    wire            take;
    wire            trig_now;
    wire            trig_edge;
    wire [15:0]     onset_neg;
    wire [DAW-1:0]  dly;
    wire [DAW-1:0]  rd_ix;
    wire [W-1:0]    smp;
    wire [16:0]     on_c;
    wire [16:0]     off_c;
    wire            sq;
    wire [19:0]     ramp11;
    wire [19:0]     span;
    wire [15:0]     gain;
    wire [W-1:0]    prod_all;
    wire            gate_nxt;

    // cosine-squared gain, 0x8000 is unity, index 16 is zero
    function [15:0] gcos;
        input [4:0] k;
        begin
            case (k)
                5'h00:   gcos = 16'h8000;
                5'h01:   gcos = 16'h7EC5;
                5'h02:   gcos = 16'h7B21;
                5'h03:   gcos = 16'h7537;
                5'h04:   gcos = 16'h6D41;
                5'h05:   gcos = 16'h638E;
                5'h06:   gcos = 16'h587E;
                5'h07:   gcos = 16'h4C7D;
                5'h08:   gcos = 16'h4000;
                5'h09:   gcos = 16'h3383;
                5'h0A:   gcos = 16'h2782;
                5'h0B:   gcos = 16'h1C72;
                5'h0C:   gcos = 16'h12BF;
                5'h0D:   gcos = 16'h0AC9;
                5'h0E:   gcos = 16'h04DF;
                5'h0F:   gcos = 16'h013B;
                default: gcos = 16'h0000;
            endcase
        end
    endfunction

    // input buffer: trigger travels with its sample
    abg_fifo #(
        .W  (W+1),
        .D  (FDEP),
        .AW (FAW)
    ) u_fifo (
        .mclk_i      (mclk_i),
        .rstn_i      (rstn_i),
        .in_valid_i  (s_valid_i),
        .in_data_i   ({s_trig_i, s_data_i}),
        .in_ready_o  (s_ready_o),
        .out_valid_o (f_valid),
        .out_data_o  (f_data),
        .out_ready_i (f_ready)
    );

    // a sample moves when the output slot is free or being drained
    assign f_ready = ~m_valid_o | m_ready_i;
    assign take    = f_valid & f_ready;

    // trigger polarity and onset detection
    assign trig_now  = f_data[W] ^ ctrl_r[`ABG_CTRL_INVERT]; // R6
    assign trig_edge = trig_now & ~trig_last_r;

    // onset compensation delay, clamped to the line length
    assign onset_neg = ~onset_r + 16'h0001;
    assign dly = !onset_r[15] ? {DAW{1'b0}} :
                 (onset_neg > DDEP - 1) ? DDEP[DAW-1:0] - {{(DAW-1){1'b0}}, 1'b1} :
                 onset_neg[DAW-1:0]; // R5
    assign rd_ix = wp_r - dly;
    assign smp   = (dly == {DAW{1'b0}}) ? f_data[W-1:0] : dmem[rd_ix]; // R5 R12

    // window edges in samples after the trigger, as seen at the output
    assign on_c  = onset_r[15] ? 17'h00000 : {1'b0, onset_r}; // R7
    assign off_c = ctrl_r[`ABG_CTRL_OFSREL] ?
                   on_c + {1'b0, offset_r} : // R11
                   {1'b0, offset_r} + {{(17-DAW){1'b0}}, dly}; // R7

    // ramp span: 90 percent time stretched to the full cos2 span
    assign sq     = (ramp_r < `ABG_SQ_MIN); // R4
    assign ramp11 = {4'h0, ramp_r} * `ABG_SPAN_MUL;
    assign span   = {4'h0, ramp_r} + {4'h0, ramp11[19:4]}; // R3

    // gate sequencer for one accepted sample
    always @* begin
        st_nxt  = st_r;
        idx_nxt = idx_r;
        acc_nxt = acc_r;
        cnt_nxt = cnt_r + {16'h0000, ~&cnt_r};
        on_nxt  = on_l_r;
        off_nxt = off_l_r;
        if (st_nxt == `ABG_ST_IDLE && trig_edge) begin
            st_nxt  = `ABG_ST_WAIT;
            cnt_nxt = 17'h00000;
            on_nxt  = on_c; // R8
            off_nxt = off_c; // R8
        end
        if (st_nxt == `ABG_ST_WAIT && cnt_nxt >= on_nxt) begin
            st_nxt  = sq ? `ABG_ST_HOLD : `ABG_ST_FALL; // R4
            idx_nxt = sq ? `ABG_STEPS : 5'h00; // R4
            acc_nxt = 20'h00000;
        end
        if (st_nxt == `ABG_ST_FALL) begin
            if (acc_nxt + `ABG_ACC_STEP >= span) begin
                acc_nxt = acc_nxt + `ABG_ACC_STEP - span; // R3
                idx_nxt = idx_nxt + 5'h01; // R2
            end else begin
                acc_nxt = acc_nxt + `ABG_ACC_STEP;
            end
            if (idx_nxt == `ABG_STEPS) begin
                st_nxt = `ABG_ST_HOLD; // R1
            end
        end
        if ((st_nxt == `ABG_ST_FALL || st_nxt == `ABG_ST_HOLD) &&
            cnt_nxt >= off_nxt) begin
            if (sq) begin
                st_nxt  = `ABG_ST_IDLE; // R4
                idx_nxt = 5'h00;
            end else begin
                st_nxt  = `ABG_ST_RISE;
                acc_nxt = 20'h00000;
            end
        end
        if (st_nxt == `ABG_ST_RISE) begin
            if (acc_nxt + `ABG_ACC_STEP >= span) begin
                acc_nxt = acc_nxt + `ABG_ACC_STEP - span; // R3
                idx_nxt = idx_nxt - 5'h01; // R2
            end else begin
                acc_nxt = acc_nxt + `ABG_ACC_STEP;
            end
            if (idx_nxt == 5'h00) begin
                st_nxt = `ABG_ST_IDLE; // R12
            end
        end
    end

    // gain of this sample and the gate waveform
    assign gain     = gcos(idx_nxt); // R2
    assign gate_nxt = (st_nxt == `ABG_ST_FALL) ||
                      (st_nxt == `ABG_ST_HOLD) ||
                      (st_nxt == `ABG_ST_RISE);

    // per-channel scaling by the shared gain
    genvar g;
    generate
        for (g = 0; g < NCH; g = g + 1) begin : g_ch
            wire signed [DW-1:0] x;
            wire signed [DW+16:0] p;
            assign x = smp[g*DW +: DW];
            assign p = x * $signed({1'b0, gain}); // R2
            assign prod_all[g*DW +: DW] = p[DW+14:15]; // R1 R12
        end
    endgenerate

    // delay line storage, written with every accepted sample
    always @(posedge mclk_i) begin
        if (take) begin
            dmem[wp_r] <= f_data[W-1:0]; // R5
        end
    end

    // gate state and stream output
    always @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            st_r         <= `ABG_ST_IDLE;
            idx_r        <= 5'h00;
            acc_r        <= 20'h00000;
            cnt_r        <= 17'h00000;
            on_l_r       <= 17'h00000;
            off_l_r      <= 17'h00000;
            trig_last_r  <= 1'b0;
            wp_r         <= {DAW{1'b0}};
            m_valid_o    <= 1'b0;
            m_data_o     <= {W{1'b0}};
            gate_o       <= 1'b0;
            tank_valid_o <= 1'b0;
            tank_gate_o  <= 1'b0;
        end else begin
            if (take) begin
                st_r         <= st_nxt;
                idx_r        <= idx_nxt;
                acc_r        <= acc_nxt;
                cnt_r        <= cnt_nxt;
                on_l_r       <= on_nxt;
                off_l_r      <= off_nxt;
                trig_last_r  <= trig_now;
                wp_r         <= wp_r + {{(DAW-1){1'b0}}, 1'b1};
                m_valid_o    <= 1'b1;
                m_data_o     <= prod_all; // R1
                gate_o       <= gate_nxt & ctrl_r[`ABG_CTRL_EXPORT]; // R9
                tank_valid_o <= ctrl_r[`ABG_CTRL_STORE]; // R10
                tank_gate_o  <= gate_nxt; // R10
            end else if (m_ready_i) begin
                m_valid_o    <= 1'b0;
                tank_valid_o <= 1'b0;
            end
        end
    end

    // register writes and one-cycle read data
    always @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            ctrl_r      <= `ABG_RST_CTRL;
            onset_r     <= `ABG_RST_ONSET;
            offset_r    <= `ABG_RST_OFFSET;
            ramp_r      <= `ABG_RST_RAMP;
            reg_rdata_o <= 16'h0000;
        end else begin
            if (reg_wr_i) begin
                case (reg_addr_i)
                    `ABG_REG_CTRL:   ctrl_r   <= {12'h000, reg_wdata_i[3:0]};
                    `ABG_REG_ONSET:  onset_r  <= reg_wdata_i; // R8
                    `ABG_REG_OFFSET: offset_r <= reg_wdata_i; // R8
                    `ABG_REG_RAMP:   ramp_r   <= reg_wdata_i;
                    default:         ctrl_r   <= ctrl_r;
                endcase
            end
            if (reg_rd_i) begin
                case (reg_addr_i)
                    `ABG_REG_CTRL:   reg_rdata_o <= ctrl_r;
                    `ABG_REG_ONSET:  reg_rdata_o <= onset_r;
                    `ABG_REG_OFFSET: reg_rdata_o <= offset_r;
                    `ABG_REG_RAMP:   reg_rdata_o <= ramp_r;
                    `ABG_REG_STATUS: reg_rdata_o <= {3'h0, gate_o, 2'h0, m_valid_o,
                                                     idx_r, 1'b0, st_r};
                    default:         reg_rdata_o <= 16'h0000;
                endcase
            end else begin
                reg_rdata_o <= 16'h0000;
            end
        end
    end
endmodule

`default_nettype wire

// [abg_gate_chk_assertions.sv]
// abg_gate_chk_assertions.sv - port checker for the blanking gate
// assumes: bound to abg_gate, single clock mclk_i, reset rstn_i low
`timescale 1ns/1ps
`default_nettype none

module abg_gate_chk #(
    parameter NCH = 4,
    parameter DW  = 16
) (
    input wire logic              mclk_i,
    input wire logic              rstn_i,
    input wire logic [3:0]        reg_addr_i,
    input wire logic              reg_rd_i,
    input wire logic [15:0]       reg_rdata_o,
    input wire logic              s_valid_i,
    input wire logic              s_ready_o,
    input wire logic              m_valid_o,
    input wire logic [NCH*DW-1:0] m_data_o,
    input wire logic              m_ready_i,
    input wire logic              gate_o,
    input wire logic              tank_valid_o,
    input wire logic              tank_gate_o
);
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!rstn_i);

    logic [3:0] fl_r;
    // samples taken in but not yet handed on
    always @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) fl_r <= 4'h0;
        else fl_r <= fl_r + {3'h0, s_valid_i & s_ready_o} - {3'h0, m_valid_o & m_ready_i};
    end

    sequence s_push;
        s_valid_i && s_ready_o;
    endsequence
    sequence s_stall;
        m_valid_o && !m_ready_i;
    endsequence

    a_rdata_idle: assert property (!reg_rd_i |=> reg_rdata_o == 16'h0000)
        else $error("read data not zero outside read cycle");
    a_unmapped_zero: assert property (reg_rd_i && reg_addr_i > 4'h4 |=> reg_rdata_o == 16'h0000)
        else $error("unmapped read not zero");
    a_ctrl_resv: assert property (reg_rd_i && reg_addr_i == 4'h0 |=> reg_rdata_o[15:4] == 12'h000)
        else $error("control spare bits not zero");
    a_status_bits: assert property (reg_rd_i && reg_addr_i == 4'h4 |=>
        reg_rdata_o[9] == $past(m_valid_o) && reg_rdata_o[12] == $past(gate_o))
        else $error("status bits disagree with outputs");
    a_out_hold: assert property (s_stall |=> m_valid_o && $stable(m_data_o))
        else $error("output sample changed under stall");
    a_side_hold: assert property (s_stall |=> $stable({gate_o, tank_gate_o, tank_valid_o}))
        else $error("gate outputs changed under stall");
    a_tank_pair: assert property (tank_valid_o |-> m_valid_o)
        else $error("storage strobe without output valid");
    a_answer_time: assert property (s_push ##0 fl_r == 4'h0 |-> ##1 !m_valid_o ##1 m_valid_o)
        else $error("sample not delivered two edges after push");
    a_flight_max: assert property (fl_r <= 4'h5 && (m_valid_o -> fl_r != 4'h0))
        else $error("samples in flight out of range");
endmodule

bind abg_gate abg_gate_chk #(.NCH(NCH), .DW(DW)) u_chk (
    .mclk_i(mclk_i), .rstn_i(rstn_i), .reg_addr_i(reg_addr_i), .reg_rd_i(reg_rd_i),
    .reg_rdata_o(reg_rdata_o), .s_valid_i(s_valid_i), .s_ready_o(s_ready_o),
    .m_valid_o(m_valid_o), .m_data_o(m_data_o), .m_ready_i(m_ready_i), .gate_o(gate_o),
    .tank_valid_o(tank_valid_o), .tank_gate_o(tank_gate_o));
`default_nettype wire

// [abg_src.sv]
// abg_src.sv - upstream sample source feeding the gate
// assumes: sends num_i samples after start_i; trigger level supplied by the bench
`timescale 1ns/1ps
`default_nettype none

module abg_src (
    input  wire logic        mclk_i,
    input  wire logic        rstn_i,
    input  wire logic        start_i,
    input  wire logic [7:0]  num_i,
    input  wire logic        slow_i,
    input  wire logic        trig_i,
    input  wire logic        s_ready_i,
    output logic             s_valid_o,
    output logic [63:0]      s_data_o,
    output logic             s_trig_o
);
    logic       v_r;
    logic [63:0] d_r;
    logic [7:0] left_r;
    logic [7:0] rem;

    // samples still owed after this edge
    assign rem = start_i ? num_i : left_r - {7'h00, v_r & s_ready_i};
    // hold an offered sample until taken; lines show junk when idle
    assign s_valid_o = v_r;
    assign s_data_o  = v_r ? d_r : ~d_r;
    assign s_trig_o  = v_r ? trig_i : ~trig_i;

    // offer the next sample, with random gaps in slow mode
    always @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            v_r    <= 1'b0;
            left_r <= 8'h00;
            d_r    <= 64'h0;
        end else begin
            left_r <= rem;
            if (!v_r || s_ready_i) begin
                v_r <= (rem != 8'h00) && (!slow_i || $urandom % 2 == 0);
                d_r <= {$urandom, $urandom};
            end
        end
    end
endmodule
`default_nettype wire

// [tb.sv]
// tb.sv - self-checking bench for the blanking gate
// assumes: abg_gate, abg_src and the bound checker are compiled before it
`timescale 1ns/1ps
`default_nettype none
`include "abg_defs.vh"

module tb;
    typedef struct packed {logic [63:0] d; logic [1:0] k; logic g; logic gc; logic st; logic ex;} abg_exp_t;
    logic        clk, rstn, rwr, rrd, sv, st, sr, mv, mr, go, tv, tg, trig, start, slow;
    logic [3:0]  ra;
    logic [15:0] rwd, rdat, c_s, on_s, of_s, rp_s;
    logic [63:0] sd, md;
    logic [63:0] hist [0:2047];
    logic        pe;
    int          err_count, num_checks, k, loc, t, loe, loff, tend, cyc;
    int pc [6] = '{6, 0, 9, 2, 10, 6};
    int pon [6] = '{0, 3, 2, -3, -2, 2};
    int pof [6] = '{5, 9, 4, 4, 5, 40};
    int prp [6] = '{0, 3, 0, 0, 0, 8};
    abg_exp_t q[$];

    abg_gate #(.DDEP(16), .DAW(4)) u_dut (
        .mclk_i(clk), .rstn_i(rstn), .reg_addr_i(ra), .reg_wdata_i(rwd), .reg_wr_i(rwr),
        .reg_rd_i(rrd), .reg_rdata_o(rdat), .s_valid_i(sv), .s_data_i(sd), .s_trig_i(st),
        .s_ready_o(sr), .m_valid_o(mv), .m_data_o(md), .m_ready_i(mr), .gate_o(go),
        .tank_valid_o(tv), .tank_gate_o(tg));
    abg_src u_src (
        .mclk_i(clk), .rstn_i(rstn), .start_i(start), .num_i(8'd70), .slow_i(slow),
        .trig_i(trig), .s_ready_i(sr), .s_valid_o(sv), .s_data_o(sd), .s_trig_o(st));

    task automatic chk(input logic [63:0] got, input logic [63:0] x);
        num_checks++;
        if (got !== x) begin
            err_count++;
            $display("unexpected at %0t got %h exp %h", $time, got, x);
        end
    endtask
    task automatic final_report;
        $display("checks %0d errors %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk);
        ra <= a; rwd <= d; rwr <= 1'b1;
        @(posedge clk);
        rwr <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, input logic [15:0] x);
        @(posedge clk);
        ra <= a; rrd <= 1'b1;
        @(posedge clk);
        rrd <= 1'b0;
        #1 chk(rdat, x);
    endtask

    // clock and hang limit
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            err_count++;
            final_report;
        end
        mr <= slow ? ($urandom % 3 != 0) : 1'b1;
    end

    // note the expected output of every sample taken in
    always @(posedge clk) if (rstn && sv && sr) begin : mdl
        abg_exp_t e;
        logic en;
        int n;
        hist[k] = sd;
        en = st ^ c_s[0];
        n = $signed(on_s) < 0 ? -$signed(on_s) : 0;
        if (en && !pe && k >= tend) begin
            t = k;
            loe = $signed(on_s) < 0 ? 0 : on_s;
            loff = c_s[3] ? loe + of_s : of_s + n;
            tend = k + loff + 20;
        end
        pe = en;
        e.g = k >= t + loe && k < t + loff;
        e.gc = !(k >= t + loff && k < t + loff + 2);
        e.d = e.g ? 64'h0 : hist[k - n];
        e.st = c_s[2];
        e.ex = c_s[1];
        e.k = 0;
        if (rp_s >= 4 && k >= t + loe && k < t + loff + 20)
            e.k = (k < t + loe + 4) ? 1 : (k >= t + loe + 20 && k < t + loff) ? 0 : 2;
        q.push_back(e);
        k++;
        loc++;
        trig <= (loc == 6) ^ c_s[0];
    end

    // compare each delivered sample with the oldest note
    always @(posedge clk) if (rstn && mv && mr) begin : cmp
        abg_exp_t e;
        if (q.size() == 0) chk(1, 0);
        else begin
            e = q.pop_front();
            if (e.k == 0) chk(md, e.d);
            if (e.k == 0 && e.gc) chk(go, e.ex & e.g);
            if (e.k == 0 && e.gc && e.st) chk(tg, e.g);
            if (e.k == 1) chk(md == 64'h0, 0);
            chk(tv, e.st);
        end
    end

    // reset, register checks, then one stream phase per table row
    initial begin
        void'($urandom(54110));
        foreach (hist[i]) hist[i] = 64'h0;
        {rstn, rwr, rrd, ra, rwd, trig, start, slow, mr, pe} = '0;
        {c_s, on_s, of_s, rp_s} = '0;
        t = -1000;
        repeat (8) @(posedge clk);
        rstn <= 1'b1;
        for (int a = 0; a < 5; a++) rd(a, 16'h0000);
        for (int p = 0; p < 6; p++) begin
            wr(`ABG_REG_CTRL, pc[p] | 16'hFFF0);
            wr(`ABG_REG_ONSET, pon[p]);
            wr(`ABG_REG_OFFSET, pof[p]);
            wr(`ABG_REG_RAMP, prp[p]);
            c_s = pc[p]; on_s = pon[p]; of_s = pof[p]; rp_s = prp[p];
            rd(`ABG_REG_CTRL, c_s);
            rd(`ABG_REG_ONSET, on_s);
            slow <= p % 2;
            loc = 0;
            trig <= c_s[0];
            @(posedge clk) start <= 1'b1;
            @(posedge clk) start <= 1'b0;
            // status read while samples flow, bits held against outputs by the checker
            repeat (10) @(posedge clk);
            ra <= `ABG_REG_STATUS;
            rrd <= 1'b1;
            @(posedge clk) rrd <= 1'b0;
            for (int i = 0; i < 3000 && !(loc == 70 && q.size() == 0); i++) @(posedge clk);
            chk(loc, 70);
        end
        rd(4'h7, 16'h0000);
        wr(4'hF, 16'hFFFF);
        rd(`ABG_REG_CTRL, c_s);
        rd(`ABG_REG_STATUS, 16'h0000);
        final_report;
    end
endmodule
`default_nettype wire
